// ### usx_pkg.sv
// Constants and types for the clocked serial port with register access.
// Assumes a single core clock domain; pin levels are synchronised in the top.
package usx_pkg;

  // Register index width; byte address is four times the index
  localparam int IDX_W = 10;

  // Register indices
  localparam logic [9:0] IDX_INT_FLAGS = 10'h00c;
  localparam logic [9:0] IDX_RX_STATUS = 10'h018;
  localparam logic [9:0] IDX_TX_DATA = 10'h019;
  localparam logic [9:0] IDX_RX_DATA = 10'h01a;
  localparam logic [9:0] IDX_INT_ENABLES = 10'h08c;
  localparam logic [9:0] IDX_TX_STATUS = 10'h098;
  localparam logic [9:0] IDX_BAUD = 10'h099;

  // Receive status and control fields
  localparam int RC_PORT_EN = 7;
  localparam int RC_NINE_EN = 6;
  localparam int RC_SINGLE = 5;
  localparam int RC_CONT = 4;
  localparam int RC_OVERRUN = 1;
  localparam int RC_NINTH = 0;

  // Transmit status and control fields
  localparam int TX_CLK_SRC = 7;
  localparam int TX_NINE_EN = 6;
  localparam int TX_ENABLE = 5;
  localparam int TX_CLOCKED = 4;
  localparam int TX_SHIFT_EMPTY = 1;
  localparam int TX_NINTH = 0;

  // Interrupt flag and enable fields
  localparam int IF_RECEIVE = 5;
  localparam int IF_TRANSMIT = 4;

  // Reset values
  localparam logic [7:0] RST_INT_FLAGS = 8'h00;
  localparam logic [7:0] RST_RX_STATUS = 8'h00;
  localparam logic [7:0] RST_RX_DATA = 8'h00;
  localparam logic [7:0] RST_INT_ENABLES = 8'h00;
  localparam logic [7:0] RST_TX_STATUS = 8'h02;
  localparam logic [7:0] RST_BAUD = 8'h00;

  // Word lengths in bits
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE = 4'h9;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Transmit shifter states
  typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} usx_tx_e;

endpackage

// ### usx_sync_port.sv
// Clocked half-duplex serial port: receiver with two-word buffer, transmitter,
// internal or external shift clock, and an AXI4-Lite register slave.
// Assumes pins are resolved outside from the out/oe pairs; pins are async.
//
// Contract
// - Either receive enable starts clocked reception
// - Sample data pin on shift clock falling
// - Single enable: one word, then stop
// - Continuous enable: receive until cleared
// - Both enables set behaves as continuous
// - Finished word enters buffer, sets flag
// - Receive request gated by enable; flag not
// - Receive flag read-only, clears when empty
// - Receive buffer is two-entry in-order FIFO
// - Third word into full buffer sets overrun
// - Clearing continuous enable clears overrun
// - Overrun blocks every transfer into buffer
// - Ninth bit buffered, follows read order
// - Nine-bit reception when nine enable set
// - Configure first, then set receive enable
// - Clock source clear selects external clock
// - Slave shifting continues while core sleeps
// - Two writes: first sent, second held
// - Second word loads, then transmit flag sets
// - Transmit request wakes core when enabled
// - Clocked mode and port enable claim pins
// - Master mode drives the shift clock
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ns
module usx_sync_port #(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic shift_clock_pin_in,
  output logic shift_clock_pin_out,
  output logic shift_clock_pin_oe,
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe,
  output logic rx_irq,
  output logic tx_irq,
  output logic wake_request
);

  // All state of the port
  typedef struct packed {
    logic awready;                // Bus handshake flops
    logic wready;
    logic arready;
    logic aw_held;
    logic w_held;
    logic [9:0] aw_idx;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic port_enable;            // Control bits
    logic rx_nine_bit_enable;
    logic single_receive_enable;
    logic continuous_receive_enable;
    logic overrun_error;
    logic clock_source_select;
    logic tx_nine_bit_enable;
    logic transmit_enable;
    logic clocked_mode_select;
    logic tx_ninth_bit;
    logic receive_irq_enable;
    logic transmit_irq_enable;
    logic [7:0] baud_divisor;
    logic ck_s1;                  // Pin synchronisers
    logic ck_s2;
    logic ck_s3;
    logic dt_s1;
    logic dt_s2;
    logic [7:0] brg_count;        // Master clock divider
    logic ck_int;
    logic [8:0] rx_shift;         // Receive path
    logic [3:0] rx_bits;
    logic [1:0][8:0] rx_fifo;
    logic rx_head;
    logic [1:0] rx_count;
    logic [7:0] tx_buffer;        // Transmit path
    logic tx_full;
    logic [8:0] tx_shift;
    logic [3:0] tx_bits;
    usx_pkg::usx_tx_e tx_state;
    logic ck_out;                 // Registered pin drives
    logic ck_oe;
    logic dt_out;
    logic dt_oe;
    logic rx_irq;                 // Registered requests
    logic tx_irq;
    logic wake;
  } usx_state_s;

  usx_state_s q;
  usx_state_s next_q;

  // Register index from a byte address
  function automatic logic [9:0] reg_index(input logic [ADDR_W-1:0] addr);
    reg_index = addr[11:2];
  endfunction

  // Whether an index names a register
  function automatic logic is_mapped(input logic [9:0] idx);
    is_mapped = (idx == usx_pkg::IDX_INT_FLAGS) || (idx == usx_pkg::IDX_RX_STATUS)
      || (idx == usx_pkg::IDX_TX_DATA) || (idx == usx_pkg::IDX_RX_DATA)
      || (idx == usx_pkg::IDX_INT_ENABLES) || (idx == usx_pkg::IDX_TX_STATUS)
      || (idx == usx_pkg::IDX_BAUD);
  endfunction

  // Decoded conditions, shared with the checks below
  logic clocked_on;
  logic rx_active;
  logic rise_ev;
  logic fall_ev;
  logic word_done;
  logic tx_load;
  logic wr_fire;
  logic rd_fire;
  logic [9:0] rd_idx;
  logic [8:0] rx_word;
  logic [3:0] rx_len;
  logic [3:0] tx_len;
  logic [8:0] head_word;
  logic [7:0] rd_val;
  logic [1:0] cnt_after_pop;

  // Next-state logic
  always_comb
  begin
    next_q = q;
    clocked_on = q.port_enable && q.clocked_mode_select;
    rx_active = clocked_on && (q.single_receive_enable || q.continuous_receive_enable);
    rx_len = q.rx_nine_bit_enable ? usx_pkg::BITS_NINE : usx_pkg::BITS_EIGHT;
    tx_len = q.tx_nine_bit_enable ? usx_pkg::BITS_NINE : usx_pkg::BITS_EIGHT;
    head_word = q.rx_fifo[q.rx_head];
    rise_ev = 1'b0;
    fall_ev = 1'b0;
    word_done = 1'b0;
    tx_load = 1'b0;
    rx_word = '0;
    rd_idx = reg_index(s_axi_araddr);
    rd_fire = s_axi_arvalid && q.arready;
    wr_fire = q.aw_held && q.w_held && !q.bvalid;
    rd_val = 8'h00;
    cnt_after_pop = q.rx_count;

    // Pin synchronisers; the second stage feeds logic, and the clock's third stage feeds edge detection
    next_q.ck_s1 = shift_clock_pin_in;
    next_q.ck_s2 = q.ck_s1;
    next_q.ck_s3 = q.ck_s2;
    next_q.dt_s1 = serial_data_pin_in;
    next_q.dt_s2 = q.dt_s1;

    // Master divider: half period is divisor plus one cycles
    // Clock starts only with an enable
    if (clocked_on && q.clock_source_select
        && (q.transmit_enable || q.single_receive_enable || q.continuous_receive_enable))
    begin
      if (q.brg_count == q.baud_divisor)
      begin
        next_q.brg_count = 8'h00;
        next_q.ck_int = !q.ck_int;
        rise_ev = !q.ck_int;
        fall_ev = q.ck_int;
      end
      else
      begin
        next_q.brg_count = q.brg_count + 8'h01;
      end
    end
    else
    begin
      // Divider held in reset while idle
      next_q.brg_count = 8'h00;
      next_q.ck_int = 1'b0;
    end

    // External clock edges in slave mode
    if (!q.clock_source_select)
    begin
      // Slave edges need no core activity
      rise_ev = q.ck_s2 && !q.ck_s3;
      fall_ev = !q.ck_s2 && q.ck_s3;
    end

    // Bus: capture write address and data independently
    if (s_axi_awvalid && q.awready)
    begin
      next_q.aw_held = 1'b1;
      next_q.aw_idx = reg_index(s_axi_awaddr);
    end
    if (s_axi_wvalid && q.wready)
    begin
      next_q.w_held = 1'b1;
      next_q.w_data = s_axi_wdata[7:0];
      next_q.w_lane0 = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready)
    begin
      next_q.bvalid = 1'b0;
    end
    if (s_axi_rvalid && s_axi_rready)
    begin
      next_q.rvalid = 1'b0;
    end

    // Transmit shifter runs first so a same-cycle write is not lost
    if (!(clocked_on && q.transmit_enable))
    begin
      // Clearing the enable resets the transmitter
      next_q.tx_state = usx_pkg::TX_IDLE;
      next_q.tx_bits = 4'h0;
    end
    else
    begin
      case (q.tx_state)
        usx_pkg::TX_IDLE:
        begin
          // Waiting word moves to shifter at once
          if (q.tx_full)
          begin
            tx_load = 1'b1;
            next_q.tx_full = 1'b0;
            next_q.tx_shift = {q.tx_ninth_bit, q.tx_buffer};
            next_q.tx_bits = 4'h0;
            next_q.tx_state = usx_pkg::TX_SHIFT;
          end
        end
        usx_pkg::TX_SHIFT:
        begin
          // Paused, not reset, while a receive enable is set
          if (rise_ev && !(q.single_receive_enable || q.continuous_receive_enable))
          begin
            if (q.tx_bits < tx_len)
            begin
              next_q.dt_out = q.tx_shift[0];
              next_q.tx_shift = {1'b0, q.tx_shift[8:1]};
              next_q.tx_bits = q.tx_bits + 4'h1;
            end
            else
            begin
              next_q.tx_state = usx_pkg::TX_IDLE;
            end
          end
        end
        default:
        begin
          next_q.tx_state = usx_pkg::TX_IDLE;
        end
      endcase
    end

    // Register read with its side effects
    if (rd_fire)
    begin
      case (rd_idx)
        usx_pkg::IDX_INT_FLAGS:
        begin
          rd_val = 8'h00;
          rd_val[usx_pkg::IF_RECEIVE] = (q.rx_count != 2'h0);
          rd_val[usx_pkg::IF_TRANSMIT] = !q.tx_full;
        end
        usx_pkg::IDX_RX_STATUS:
        begin
          // Ninth bit of the oldest word, read before data
          rd_val = {q.port_enable, q.rx_nine_bit_enable, q.single_receive_enable,
            q.continuous_receive_enable, 2'b00, q.overrun_error, head_word[8]};
        end
        usx_pkg::IDX_RX_DATA:
        begin
          rd_val = head_word[7:0];
          // Pop exposes next word and its ninth bit
          if (q.rx_count != 2'h0)
          begin
            next_q.rx_head = !q.rx_head;
            cnt_after_pop = q.rx_count - 2'h1;
          end
        end
        usx_pkg::IDX_INT_ENABLES:
        begin
          rd_val = 8'h00;
          rd_val[usx_pkg::IF_RECEIVE] = q.receive_irq_enable;
          rd_val[usx_pkg::IF_TRANSMIT] = q.transmit_irq_enable;
        end
        usx_pkg::IDX_TX_STATUS:
        begin
          rd_val = {q.clock_source_select, q.tx_nine_bit_enable, q.transmit_enable,
            q.clocked_mode_select, 2'b00, q.tx_state == usx_pkg::TX_IDLE, q.tx_ninth_bit};
        end
        usx_pkg::IDX_BAUD:
        begin
          rd_val = q.baud_divisor;
        end
        default:
        begin
          rd_val = 8'h00;
        end
      endcase
      next_q.rvalid = 1'b1;
      next_q.rdata = {24'h00_0000, rd_val};
      next_q.rresp = is_mapped(rd_idx) ? usx_pkg::RESP_OKAY : usx_pkg::RESP_SLVERR;
    end

    // Register write; hardware events below win over it
    if (wr_fire)
    begin
      next_q.aw_held = 1'b0;
      next_q.w_held = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.bresp = is_mapped(q.aw_idx) ? usx_pkg::RESP_OKAY : usx_pkg::RESP_SLVERR;
      if (q.w_lane0)
      begin
        case (q.aw_idx)
          usx_pkg::IDX_RX_STATUS:
          begin
            next_q.port_enable = q.w_data[usx_pkg::RC_PORT_EN];
            next_q.rx_nine_bit_enable = q.w_data[usx_pkg::RC_NINE_EN];
            next_q.single_receive_enable = q.w_data[usx_pkg::RC_SINGLE];
            next_q.continuous_receive_enable = q.w_data[usx_pkg::RC_CONT];
            // Only clearing the continuous enable clears overrun
            if (!q.w_data[usx_pkg::RC_CONT])
            begin
              next_q.overrun_error = 1'b0;
            end
          end
          usx_pkg::IDX_TX_DATA:
          begin
            // Second word stays held while shifter busy
            next_q.tx_buffer = q.w_data;
            next_q.tx_full = 1'b1;
          end
          usx_pkg::IDX_INT_ENABLES:
          begin
            next_q.receive_irq_enable = q.w_data[usx_pkg::IF_RECEIVE];
            next_q.transmit_irq_enable = q.w_data[usx_pkg::IF_TRANSMIT];
          end
          usx_pkg::IDX_TX_STATUS:
          begin
            next_q.clock_source_select = q.w_data[usx_pkg::TX_CLK_SRC];
            next_q.tx_nine_bit_enable = q.w_data[usx_pkg::TX_NINE_EN];
            next_q.transmit_enable = q.w_data[usx_pkg::TX_ENABLE];
            next_q.clocked_mode_select = q.w_data[usx_pkg::TX_CLOCKED];
            next_q.tx_ninth_bit = q.w_data[usx_pkg::TX_NINTH];
          end
          usx_pkg::IDX_BAUD:
          begin
            next_q.baud_divisor = q.w_data;
          end
          default:
          begin
            // Flags and receive data ignore writes
            next_q.tx_buffer = next_q.tx_buffer;
          end
        endcase
      end
    end

    // Bit counter held clear while reception is off
    if (!rx_active)
    begin
      next_q.rx_bits = 4'h0;
    end
    // Sample on the falling shift clock edge
    else if (fall_ev)
    begin
      next_q.rx_shift = {q.dt_s2, q.rx_shift[8:1]};
      next_q.rx_bits = q.rx_bits + 4'h1;
      // Word length follows the nine-bit enable
      if ((q.rx_bits + 4'h1) == rx_len)
      begin
        word_done = 1'b1;
        next_q.rx_bits = 4'h0;
        rx_word = q.rx_nine_bit_enable ? {q.dt_s2, q.rx_shift[8:1]}
          : {1'b0, q.dt_s2, q.rx_shift[8:2]};
        if (q.overrun_error)
        begin
          next_q.rx_count = cnt_after_pop;
        end
        else if (cnt_after_pop != 2'h2)
        begin
          next_q.rx_fifo[next_q.rx_head ^ cnt_after_pop[0]] = rx_word;
          cnt_after_pop = cnt_after_pop + 2'h1;
        end
        // Full buffer: set overrun, drop the word
        else
        begin
          next_q.overrun_error = 1'b1;
        end
        // Single mode ends unless continuous is set
        if (!q.continuous_receive_enable)
        begin
          next_q.single_receive_enable = 1'b0;
        end
      end
    end
    // Flag is the buffer count, cleared by reads only
    next_q.rx_count = cnt_after_pop;

    next_q.ck_oe = next_q.port_enable && next_q.clocked_mode_select
      && next_q.clock_source_select;
    next_q.ck_out = next_q.ck_int;
    next_q.dt_oe = next_q.port_enable && next_q.clocked_mode_select
      && next_q.transmit_enable
      && !(next_q.single_receive_enable || next_q.continuous_receive_enable);

    // Requests gated by enables; flags are not
    next_q.rx_irq = (next_q.rx_count != 2'h0) && next_q.receive_irq_enable;
    // Transmit request also wakes the core
    next_q.tx_irq = !next_q.tx_full && next_q.transmit_irq_enable;
    next_q.wake = next_q.rx_irq || next_q.tx_irq;

    // Bus ready flags follow pending state
    next_q.awready = !next_q.aw_held && !next_q.bvalid;
    next_q.wready = !next_q.w_held && !next_q.bvalid;
    next_q.arready = !next_q.rvalid;

    // Synchronous reset
    if (!aresetn)
    begin
      next_q = '0;
      next_q.baud_divisor = usx_pkg::RST_BAUD;
      next_q.tx_ninth_bit = usx_pkg::RST_TX_STATUS[usx_pkg::TX_NINTH];
      next_q.receive_irq_enable = usx_pkg::RST_INT_ENABLES[usx_pkg::IF_RECEIVE];
      next_q.port_enable = usx_pkg::RST_RX_STATUS[usx_pkg::RC_PORT_EN];
      next_q.tx_state = usx_pkg::TX_IDLE;
    end
  end

  // State register
  always_ff @(posedge aclk)
  begin
    q <= next_q;
  end

  // Outputs straight from flops
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rdata = q.rdata;
  assign shift_clock_pin_out = q.ck_out;
  assign shift_clock_pin_oe = q.ck_oe;
  assign serial_data_pin_out = q.dt_out;
  assign serial_data_pin_oe = q.dt_oe;
  assign rx_irq = q.rx_irq;
  assign tx_irq = q.tx_irq;
  assign wake_request = q.wake;

  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_overrun_blocks_push: assert property (
    q.overrun_error |=> (q.rx_count <= $past(q.rx_count)))
    else $error("buffer grew while overrun set");

  a_overrun_on_full: assert property (
    (word_done && !rd_fire && q.rx_count == 2'h2) |=> q.overrun_error)
    else $error("overrun not set on full buffer");

  a_overrun_clear: assert property (
    ($fell(q.continuous_receive_enable) && !$past(word_done)) |-> !q.overrun_error)
    else $error("overrun survived continuous enable clear");

  a_single_stops: assert property (
    (word_done && q.single_receive_enable && !q.continuous_receive_enable)
    |=> !q.single_receive_enable)
    else $error("single reception did not stop");

  a_cont_precedence: assert property (
    (word_done && q.continuous_receive_enable && q.single_receive_enable && !wr_fire)
    |=> (q.single_receive_enable && q.continuous_receive_enable))
    else $error("continuous setting not kept");

  a_idle_counter: assert property (
    !(q.single_receive_enable || q.continuous_receive_enable) |=> (q.rx_bits == 4'h0))
    else $error("bit counter moved while disabled");

  a_falling_sample: assert property (
    (q.rx_bits != $past(q.rx_bits) && q.rx_bits != 4'h0) |-> $past(fall_ev))
    else $error("bit taken without falling edge");

  a_rx_irq_gate: assert property (
    q.rx_irq |-> (q.receive_irq_enable && q.rx_count != 2'h0))
    else $error("receive request without flag and enable");

  a_tx_flag_load: assert property (
    (tx_load && !wr_fire) |=> (!q.tx_full ##1 (q.tx_irq == q.transmit_irq_enable)))
    else $error("transmit flag not set after load");

endmodule

// ### usx_peer.sv
// Far-side serial device model: feeds data to the port, or clocks it out.
// Assumes the bench resolves both pins from the port's output enables.
`timescale 1ns/1ns
module usx_peer (
  input wire logic sck,
  input wire logic mst,
  input wire logic dt,
  output logic sck_drv,
  output logic dt_drv
);
  // Bits waiting to go out, words captured
  logic bq[$];
  logic [8:0] got[$];
  // Clock stands low between frames
  initial
  begin
    sck_drv = 1'b0;
    dt_drv = 1'b1;
  end
  // Queue a word LSB first; each bit goes out on a rising clock edge
  task automatic load(input logic [8:0] w, input int n);
    for (int i = 0; i < n; i++)
      bq.push_back(w[i]);
  endtask
  // Bit changes at the rise, stands over the port's falling sample
  always @(posedge sck)
    if (mst)
      dt_drv <= (bq.size() > 0) ? bq.pop_front() : ~dt_drv;
  // External clock: n data pulses, one freeing pulse
  task automatic clock_word(input int n);
    logic [8:0] w;
    w = '0;
    // Edges kept off the core clock edge
    #2;
    for (int i = 0; i <= n; i++)
    begin
      sck_drv = 1'b1;
      #40;
      sck_drv = 1'b0;
      #39;
      if (i < n)
        w[i] = dt;
      #1;
    end
    got.push_back(w);
  endtask
endmodule

// ### tb_usx_sync_port.sv
// Self-checking bench for the clocked serial port with register access.
// Assumes the package, the design and the peer model compile first.
`timescale 1ns/1ns
module tb_usx_sync_port;
  logic aclk, aresetn;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, r;
  logic [1:0] bresp, rresp, rs;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic sck_o, sck_oe, dt_o, dt_oe, rx_irq, tx_irq, wake, p_sck, p_dt;
  // Resolved pin levels
  wire logic sck = sck_oe ? sck_o : p_sck;
  wire logic dt = dt_oe ? dt_o : p_dt;
  int err_count, total_checks;
  // Receive model: two-deep queue and overrun
  logic [8:0] mq[$];
  logic m_ovr;
  logic [8:0] x;
  logic [8:0] w[3];
  usx_sync_port i_usx_sync_port (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .shift_clock_pin_in(sck),
    .shift_clock_pin_out(sck_o), .shift_clock_pin_oe(sck_oe),
    .serial_data_pin_in(dt), .serial_data_pin_out(dt_o),
    .serial_data_pin_oe(dt_oe), .rx_irq(rx_irq), .tx_irq(tx_irq),
    .wake_request(wake));
  usx_peer i_usx_peer (.sck(sck), .mst(sck_oe), .dt(dt), .sck_drv(p_sck),
    .dt_drv(p_dt));
  // Core clock
  always #5 aclk = ~aclk;
  // Count and report one comparison
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Bus write, both halves offered together
  task automatic wr(input logic [9:0] ix, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= {ix, 2'b00};
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (!awready);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!wready);
        wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    chk({30'h0000_0000, bresp}, {30'h0000_0000, usx_pkg::RESP_OKAY});
  endtask
  // Bus read into r and rs
  task automatic rd(input logic [9:0] ix);
    @(posedge aclk);
    araddr <= {ix, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    r = rdata;
    rs = rresp;
  endtask
  task automatic rdc(input logic [9:0] ix, input logic [31:0] e);
    rd(ix);
    chk(r, e);
  endtask
  // Word arrives at the model buffer
  task automatic model_rx(input logic [8:0] v);
    if (m_ovr || mq.size() == 2)
      m_ovr = 1'b1;
    else
      mq.push_back(v);
  endtask
  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    #400_000;
    err_count++;
    finish_test();
  end
  // Main sequence
  initial
  begin
    aclk = 0; aresetn = 0; awaddr = 0; araddr = 0; wdata = 0;
    awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    err_count = 0; total_checks = 0; m_ovr = 0;
    void'($urandom(95215));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values; transmit buffer empty shows in the flags
    rdc(usx_pkg::IDX_INT_FLAGS, 32'h0000_0010);
    rdc(usx_pkg::IDX_RX_STATUS, 32'h0000_0000);
    rdc(usx_pkg::IDX_RX_DATA, 32'h0000_0000);
    rdc(usx_pkg::IDX_INT_ENABLES, 32'h0000_0000);
    rdc(usx_pkg::IDX_TX_STATUS, 32'h0000_0002);
    rdc(usx_pkg::IDX_BAUD, 32'h0000_0000);
    rd(10'h3ff);
    chk({30'h0000_0000, rs}, {30'h0000_0000, usx_pkg::RESP_SLVERR});
    // Master single-word reception
    x = 9'($urandom);
    // Half period of five cycles covers the pin synchroniser delay
    wr(usx_pkg::IDX_BAUD, 8'h04);
    wr(usx_pkg::IDX_TX_STATUS, 8'h90);
    wr(usx_pkg::IDX_INT_ENABLES, 8'h20);
    wr(usx_pkg::IDX_RX_STATUS, 8'h80);
    i_usx_peer.load(x, 8);
    wr(usx_pkg::IDX_RX_STATUS, 8'ha0);
    model_rx({1'b0, x[7:0]});
    for (int n = 0; n < 300 && rx_irq !== 1'b1; n++)
      @(posedge aclk);
    chk({31'h0000_0000, rx_irq}, 32'h0000_0001);
    rdc(usx_pkg::IDX_INT_FLAGS, 32'h0000_0030);
    rdc(usx_pkg::IDX_RX_STATUS, 32'h0000_0080);
    x = mq.pop_front();
    rdc(usx_pkg::IDX_RX_DATA, {24'h00_0000, x[7:0]});
    rdc(usx_pkg::IDX_INT_FLAGS, 32'h0000_0010);
    // Nine-bit, both enables, three words into a two-deep buffer
    wr(usx_pkg::IDX_RX_STATUS, 8'hc0);
    foreach (w[i])
    begin
      w[i] = 9'($urandom);
      i_usx_peer.load(w[i], 9);
      model_rx(w[i]);
    end
    wr(usx_pkg::IDX_RX_STATUS, 8'hf0);
    for (int n = 0; n < 600 && i_usx_peer.bq.size() > 0; n++)
      @(posedge aclk);
    repeat (20) @(posedge aclk);
    rdc(usx_pkg::IDX_RX_STATUS, {24'h00_0000, 7'h79, mq[0][8]});
    wr(usx_pkg::IDX_RX_STATUS, 8'hc0);
    m_ovr = 1'b0;
    repeat (2)
    begin
      x = mq.pop_front();
      rdc(usx_pkg::IDX_RX_STATUS, {24'h00_0000, 7'h60, x[8]});
      rdc(usx_pkg::IDX_RX_DATA, {24'h00_0000, x[7:0]});
    end
    rdc(usx_pkg::IDX_INT_FLAGS, 32'h0000_0010);
    // Slave transmission of two words on an external clock
    wr(usx_pkg::IDX_RX_STATUS, 8'h80);
    wr(usx_pkg::IDX_TX_STATUS, 8'h30);
    wr(usx_pkg::IDX_INT_ENABLES, 8'h10);
    wr(usx_pkg::IDX_TX_DATA, w[0][7:0]);
    wr(usx_pkg::IDX_TX_DATA, w[1][7:0]);
    rdc(usx_pkg::IDX_INT_FLAGS, 32'h0000_0000);
    i_usx_peer.clock_word(8);
    rdc(usx_pkg::IDX_INT_FLAGS, 32'h0000_0010);
    chk({30'h0000_0000, tx_irq, wake}, 32'h0000_0003);
    i_usx_peer.clock_word(8);
    // Nine-bit word: ninth bit set before the data is loaded
    wr(usx_pkg::IDX_TX_STATUS, {7'h38, w[2][8]});
    wr(usx_pkg::IDX_TX_DATA, w[2][7:0]);
    i_usx_peer.clock_word(9);
    // Eight-bit words carry no ninth bit
    w[0][8] = 1'b0;
    w[1][8] = 1'b0;
    for (int i = 0; i < 3; i++)
      chk({23'h00_0000, i_usx_peer.got[i]}, {23'h00_0000, w[i]});
    finish_test();
  end
endmodule
